// ==== shared/fieldbus_led_pkg.sv ====
// constants and types for the fieldbus status led block
package fieldbus_led_pkg;

  // system clock and the 1 ms pattern time base
  localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned TICK_CYCLES    =
    (CLK_FREQ_HZ / 1_000_000) * TICK_PERIOD_US;

  // pattern phase lengths in milliseconds
  localparam int unsigned FLICKER_PHASE_MS = 50;
  localparam int unsigned BLINK_PHASE_MS   = 200;
  localparam int unsigned FLASH_ON_MS      = 200;
  localparam int unsigned FLASH_GAP_MS     = 200;
  localparam int unsigned FLASH_PAUSE_MS   = 1000;

  // traffic is seen as present this long after the last activity pulse
  localparam int unsigned ACT_HOLD_MS = 100;

  // millisecond counter width, covers the longest phase
  localparam int unsigned MS_CNT_W = 10;
  localparam int unsigned PHASE_W  = 2;

  // default number of link ports (input port and output port)
  localparam int unsigned NUM_PORTS_DEF = 2;

  // generator slots: run, error, then one per port
  localparam int unsigned RUN_SLOT  = 0;
  localparam int unsigned ERR_SLOT  = 1;
  localparam int unsigned LINK_SLOT = 2;

  // led patterns
  typedef enum logic [2:0] {
    PAT_OFF,
    PAT_ON,
    PAT_FLICKER,
    PAT_BLINK,
    PAT_SINGLE,
    PAT_DOUBLE
  } led_pattern_e;

  // fieldbus state machine states as reported by the protocol controller
  typedef enum logic [2:0] {
    FSM_INIT,
    FSM_PREOP,
    FSM_SAFEOP,
    FSM_OP,
    FSM_BOOT
  } fsm_state_e;

endpackage

// ==== shared/led_pattern_if.sv ====
// carrier between the led controller and one pattern generator
`timescale 1ns/1ps
interface led_pattern_if;
  import fieldbus_led_pkg::*;

  logic         tick;     // 1 ms enable pulse
  led_pattern_e pattern;  // selected pattern
  logic         led;      // resulting led level

  modport ctl (output tick, output pattern, input led);
  modport gen (input tick, input pattern, output led);
endinterface

// ==== verilog/led_pattern_gen.sv ====
// one led pattern generator driven by a 1 ms tick
`timescale 1ns/1ps
module led_pattern_gen (
  input  wire logic  core_clk_i,
  input  wire logic  rstn_i,
  led_pattern_if.gen pat
);
  import fieldbus_led_pkg::*;

  localparam logic [MS_CNT_W-1:0] LEN_FLICK = MS_CNT_W'(FLICKER_PHASE_MS);
  localparam logic [MS_CNT_W-1:0] LEN_BLINK = MS_CNT_W'(BLINK_PHASE_MS);
  localparam logic [MS_CNT_W-1:0] LEN_F_ON  = MS_CNT_W'(FLASH_ON_MS);
  localparam logic [MS_CNT_W-1:0] LEN_F_GAP = MS_CNT_W'(FLASH_GAP_MS);
  localparam logic [MS_CNT_W-1:0] LEN_PAUSE = MS_CNT_W'(FLASH_PAUSE_MS);
  localparam logic [MS_CNT_W-1:0] LEN_ONE   = MS_CNT_W'(1);

  led_pattern_e               active;
  logic [PHASE_W-1:0]         phase;
  logic [MS_CNT_W-1:0]        ms_cnt;
  logic [MS_CNT_W-1:0]        phase_len;
  logic [PHASE_W-1:0]         last_phase;
  logic                       lit;

  // phase length, last phase and lit level per pattern
  always_comb begin
    phase_len  = LEN_ONE;
    last_phase = '0;
    lit        = 1'b0;
    case (active)
      PAT_OFF: begin
        lit = 1'b0;
      end
      PAT_ON: begin
        lit = 1'b1;
      end
      // 50 ms on, 50 ms off
      PAT_FLICKER: begin
        phase_len  = LEN_FLICK;
        last_phase = PHASE_W'(1);
        lit        = (phase == '0);
      end
      // 200 ms on, 200 ms off
      PAT_BLINK: begin
        phase_len  = LEN_BLINK;
        last_phase = PHASE_W'(1);
        lit        = (phase == '0);
      end
      // 200 ms on, 1000 ms off
      PAT_SINGLE: begin
        phase_len  = (phase == '0) ? LEN_F_ON : LEN_PAUSE;
        last_phase = PHASE_W'(1);
        lit        = (phase == '0);
      end
      PAT_DOUBLE: begin
        case (phase)
          2'd0:    phase_len = LEN_F_ON;
          2'd1:    phase_len = LEN_F_GAP;
          2'd2:    phase_len = LEN_F_ON;
          default: phase_len = LEN_PAUSE;
        endcase
        last_phase = PHASE_W'(3);
        lit        = (phase == 2'd0) || (phase == 2'd2);
      end
      default: begin
        lit = 1'b0;
      end
    endcase
  end

  // phase sequencer, restarts on every pattern change
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active <= PAT_OFF;
      phase  <= '0;
      ms_cnt <= '0;
    end else if (pat.pattern != active) begin
      active <= pat.pattern;
      phase  <= '0;
      ms_cnt <= '0;
    end else if (pat.tick) begin
      if (ms_cnt >= phase_len - LEN_ONE) begin
        ms_cnt <= '0;
        phase  <= (phase >= last_phase) ? '0 : phase + PHASE_W'(1);
      end else begin
        ms_cnt <= ms_cnt + LEN_ONE;
      end
    end
  end

  assign pat.led = lit;

endmodule

// ==== verilog/fieldbus_status_leds.sv ====
// run, error and link/activity indicator pattern controller
`timescale 1ns/1ps

// What this block does
// - flickering toggles the led every 50 ms, a 10 Hz cycle
// - blinking toggles the led every 200 ms, a 2.5 Hz cycle
// - single flash: 200 ms on, 1000 ms off, repeated
// - double flash: 200 on, 200 off, 200 on, 1000 off, repeated
// - on pattern stays lit, off pattern stays dark
// - run led dark in init state and while unpowered or in reset
// - run led blinks in the pre-operational state
// - run led single-flashes in the safe-operational state
// - run led steadily lit in the operational state
// - error led dark without errors, blinks on refused state change
// - error led single-flashes after a self-initiated error state change
// - error led double-flashes on a sync manager watchdog error
// - error led steadily lit on a critical error
// - link led dark without link and while unpowered or in reset
// - link led steadily lit with link and no traffic
// - link led flickers with link and traffic
// - one link led per port, each showing only its own port
module fieldbus_status_leds
  import fieldbus_led_pkg::*;
#(
  parameter int unsigned NUM_PORTS   = NUM_PORTS_DEF,
  parameter int unsigned TICK_CYCLES = fieldbus_led_pkg::TICK_CYCLES,
  parameter int unsigned ACT_HOLD    = ACT_HOLD_MS
) (
  input  wire logic                         core_clk_i,
  input  wire logic                         rstn_i,
  input  wire fieldbus_led_pkg::fsm_state_e fsm_state_i,
  input  wire logic                         err_refused_i,
  input  wire logic                         err_self_change_i,
  input  wire logic                         err_sm_watchdog_i,
  input  wire logic                         err_critical_i,
  input  wire logic [NUM_PORTS-1:0]         link_up_i,
  input  wire logic [NUM_PORTS-1:0]         activity_i,
  output logic                              run_state_led_o,
  output logic                              error_state_led_o,
  output logic [NUM_PORTS-1:0]              link_led_o
);
  import fieldbus_led_pkg::*;

  localparam int unsigned NUM_SLOTS = LINK_SLOT + NUM_PORTS;
  localparam int unsigned DIV_W     = (TICK_CYCLES > 1) ?
                                      $clog2(TICK_CYCLES) : 1;
  localparam int unsigned HOLD_W    = (ACT_HOLD > 1) ?
                                      $clog2(ACT_HOLD + 1) : 1;
  localparam logic [DIV_W-1:0]  DIV_LAST = DIV_W'(TICK_CYCLES - 1);
  localparam logic [DIV_W-1:0]  DIV_ONE  = DIV_W'(1);
  localparam logic [HOLD_W-1:0] HOLD_TOP = HOLD_W'(ACT_HOLD);
  localparam logic [HOLD_W-1:0] HOLD_ONE = HOLD_W'(1);

  // refuse settings the logic cannot serve
  if (NUM_PORTS < 1) begin : g_bad_ports
    $error("NUM_PORTS must be at least 1");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end
  if (ACT_HOLD < 1) begin : g_bad_hold
    $error("ACT_HOLD must be at least 1");
  end

  logic [DIV_W-1:0]    div_cnt;
  logic                tick;
  led_pattern_e        run_pattern;
  led_pattern_e        err_pattern;
  logic [NUM_PORTS-1:0] traffic;
  led_pattern_e        link_pattern [NUM_PORTS];

  led_pattern_if pat_if [NUM_SLOTS] ();

  // 1 ms enable from system clock
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else begin
      tick <= (div_cnt == DIV_LAST);
      if (div_cnt == DIV_LAST) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + DIV_ONE;
      end
    end
  end

  // run led pattern from the state machine state
  always_comb begin
    case (fsm_state_i)
      FSM_INIT:   run_pattern = PAT_OFF;
      FSM_PREOP:  run_pattern = PAT_BLINK;
      FSM_SAFEOP: run_pattern = PAT_SINGLE;
      FSM_OP:     run_pattern = PAT_ON;
      default:    run_pattern = PAT_OFF;
    endcase
  end

  // error led pattern, most severe condition first
  always_comb begin
    if (err_critical_i) begin
      err_pattern = PAT_ON;
    end else if (err_sm_watchdog_i) begin
      err_pattern = PAT_DOUBLE;
    end else if (err_self_change_i) begin
      err_pattern = PAT_SINGLE;
    end else if (err_refused_i) begin
      err_pattern = PAT_BLINK;
    end else begin
      err_pattern = PAT_OFF;
    end
  end

  // per-port traffic detect and link pattern
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [HOLD_W-1:0] hold_cnt;

    // stretch short activity pulses so the flicker is visible
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        hold_cnt <= '0;
      end else if (activity_i[p]) begin
        hold_cnt <= HOLD_TOP;
      end else if (tick && (hold_cnt != '0)) begin
        hold_cnt <= hold_cnt - HOLD_ONE;
      end
    end

    assign traffic[p] = activity_i[p] || (hold_cnt != '0);

    always_comb begin
      if (!link_up_i[p]) begin
        link_pattern[p] = PAT_OFF;
      end else if (traffic[p]) begin
        link_pattern[p] = PAT_FLICKER;
      end else begin
        link_pattern[p] = PAT_ON;
      end
    end

    assign pat_if[LINK_SLOT + p].pattern = link_pattern[p];
  end

  assign pat_if[RUN_SLOT].pattern = run_pattern;
  assign pat_if[ERR_SLOT].pattern = err_pattern;

  // one generator per led, all on the shared tick
  for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
    assign pat_if[s].tick = tick;

    led_pattern_gen u_gen (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .pat        (pat_if[s].gen)
    );
  end

  // registered run and error outputs, dark in reset
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_state_led_o   <= 1'b0;
      error_state_led_o <= 1'b0;
    end else begin
      run_state_led_o   <= pat_if[RUN_SLOT].led;
      error_state_led_o <= pat_if[ERR_SLOT].led;
    end
  end

  // registered link outputs, one per port
  for (genvar q = 0; q < NUM_PORTS; q++) begin : g_link_out
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        link_led_o[q] <= 1'b0;
      end else begin
        link_led_o[q] <= pat_if[LINK_SLOT + q].led;
      end
    end
  end

endmodule

// ==== tb/fieldbus_status_leds_assertions.sv ====
// concurrent checks on the status led controller ports
`timescale 1ns/1ps
module fieldbus_status_leds_assertions
  import fieldbus_led_pkg::*;
#(
  parameter int unsigned NUM_PORTS   = NUM_PORTS_DEF,
  parameter int unsigned TICK_CYCLES = fieldbus_led_pkg::TICK_CYCLES,
  parameter int unsigned ACT_HOLD    = ACT_HOLD_MS
) (
  input wire logic                         core_clk_i,
  input wire logic                         rstn_i,
  input wire fieldbus_led_pkg::fsm_state_e fsm_state_i,
  input wire logic                         err_refused_i,
  input wire logic                         err_self_change_i,
  input wire logic                         err_sm_watchdog_i,
  input wire logic                         err_critical_i,
  input wire logic [NUM_PORTS-1:0]         link_up_i,
  input wire logic [NUM_PORTS-1:0]         activity_i,
  input wire logic                         run_state_led_o,
  input wire logic                         error_state_led_o,
  input wire logic [NUM_PORTS-1:0]         link_led_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_reset_dark: assert property (
    @(posedge core_clk_i) disable iff (1'b0)
    !rstn_i |-> {run_state_led_o, error_state_led_o, link_led_o} == '0)
    else $error("leds lit during reset");
  a_run_init_dark: assert property (
    (fsm_state_i == FSM_INIT) [*2] |=> !run_state_led_o)
    else $error("run led lit in init state");
  a_run_op_lit: assert property (
    (fsm_state_i == FSM_OP) [*2] |=> run_state_led_o)
    else $error("run led dark in operational state");
  a_err_none_dark: assert property (
    ({err_critical_i, err_sm_watchdog_i, err_self_change_i,
      err_refused_i} == 4'h0) [*2] |=> !error_state_led_o)
    else $error("error led lit without errors");
  a_err_crit_lit: assert property (
    err_critical_i [*2] |=> error_state_led_o)
    else $error("error led dark on critical error");
  // output lags the sampled link by two edges: selection, then output flop
  a_link_down_dark: assert property (
    (link_led_o & ~$past(link_up_i, 2)) == '0)
    else $error("link led lit without link");
  // selection must be settled before the rise, else a restart may cut it
  a_run_on_phase: assert property (
    $stable(fsm_state_i) ##1 ($rose(run_state_led_o) &&
    $stable(fsm_state_i)) ##1 $stable(fsm_state_i) [*8]
    |-> run_state_led_o)
    else $error("run led on phase cut short");
  a_err_on_phase: assert property (
    $stable({err_critical_i, err_sm_watchdog_i, err_self_change_i,
      err_refused_i}) ##1 ($rose(error_state_led_o) &&
    $stable({err_critical_i, err_sm_watchdog_i, err_self_change_i,
      err_refused_i})) ##1 $stable({err_critical_i,
      err_sm_watchdog_i, err_self_change_i, err_refused_i}) [*8]
    |-> error_state_led_o)
    else $error("error led on phase cut short");
  a_link_off_phase: assert property (
    $fell(link_led_o[0]) && link_up_i[0] && $past(link_up_i[0]) &&
    activity_i[0] ##1 (link_up_i[0] && activity_i[0]) [*8]
    |-> !link_led_o[0])
    else $error("link led off phase cut short");

  c_run_blink: cover property ($rose(run_state_led_o) &&
    fsm_state_i == FSM_PREOP);
  c_err_crit: cover property (error_state_led_o && err_critical_i);
  c_link_flick: cover property ($fell(link_led_o[0]) && activity_i[0]);
endmodule

bind fieldbus_status_leds fieldbus_status_leds_assertions #(
  .NUM_PORTS(NUM_PORTS), .TICK_CYCLES(TICK_CYCLES), .ACT_HOLD(ACT_HOLD)
) i_chk (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .fsm_state_i(fsm_state_i),
  .err_refused_i(err_refused_i), .err_self_change_i(err_self_change_i),
  .err_sm_watchdog_i(err_sm_watchdog_i), .err_critical_i(err_critical_i),
  .link_up_i(link_up_i), .activity_i(activity_i),
  .run_state_led_o(run_state_led_o),
  .error_state_led_o(error_state_led_o), .link_led_o(link_led_o)
);

// ==== tb/fieldbus_status_leds_bench.sv ====
// self-checking bench for the status led controller
`timescale 1ns/1ps
module fieldbus_status_leds_bench;
  import fieldbus_led_pkg::*;
  localparam int TC = 4;
  logic       core_clk_i, rstn_i, run_state_led_o, error_state_led_o;
  logic       err_refused_i, err_self_change_i;
  logic       err_sm_watchdog_i, err_critical_i;
  logic [1:0] link_up_i, activity_i, link_led_o;
  fsm_state_e fsm_state_i;
  int         miscompares, compares, cycles;

  fieldbus_status_leds #(.NUM_PORTS(2), .TICK_CYCLES(TC), .ACT_HOLD(2)) i_dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .fsm_state_i(fsm_state_i),
    .err_refused_i(err_refused_i), .err_self_change_i(err_self_change_i),
    .err_sm_watchdog_i(err_sm_watchdog_i), .err_critical_i(err_critical_i),
    .link_up_i(link_up_i), .activity_i(activity_i),
    .run_state_led_o(run_state_led_o),
    .error_state_led_o(error_state_led_o), .link_led_o(link_led_o));

  // clock and hang guard
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      wrap_up();
    end
  end

  task wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // led by slot: run, error, then ports
  function logic led(input int s);
    return s == 0 ? run_state_led_o : s == 1 ? error_state_led_o
                  : link_led_o[s-2];
  endfunction

  // new inputs, then let the selection reach the output
  task set_in(input fsm_state_e f, input logic [3:0] e,
              input logic [1:0] lu, input logic [1:0] act);
    @(posedge core_clk_i);
    #1;
    fsm_state_i = f;
    {err_critical_i, err_sm_watchdog_i, err_self_change_i, err_refused_i} = e;
    link_up_i = lu;
    activity_i = act;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask

  task run_len(input int s, input logic v, input int cap, output int n);
    n = 0;
    while (led(s) === v && n < cap) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
  endtask

  task steady(input int s, input logic v);
    int n;
    run_len(s, v, 1200, n);
    check(n, 1200);
  endtask

  // skip the partial cycle, then time whole phases in ms
  task pattern(input int s, input int l0, l1, l2, l3);
    int n;
    check(led(s), 1'b1);
    run_len(s, 1'b1, 9000, n);
    run_len(s, 1'b0, 9000, n);
    run_len(s, 1'b1, 9000, n);
    check(n, l0 * TC);
    run_len(s, 1'b0, 9000, n);
    check(n, l1 * TC);
    if (l2 > 0) begin
      run_len(s, 1'b1, 9000, n);
      check(n, l2 * TC);
      run_len(s, 1'b0, 9000, n);
      check(n, l3 * TC);
    end
  endtask

  task t_run();
    set_in(FSM_INIT, 4'h0, 2'b00, 2'b00);
    steady(0, 1'b0);
    set_in(FSM_PREOP, 4'h0, 2'b00, 2'b00);
    pattern(0, 200, 200, 0, 0);
    set_in(FSM_SAFEOP, 4'h0, 2'b00, 2'b00);
    pattern(0, 200, 1000, 0, 0);
    set_in(FSM_OP, 4'h0, 2'b00, 2'b00);
    steady(0, 1'b1);
    set_in(FSM_BOOT, 4'h0, 2'b00, 2'b00);
    steady(0, 1'b0);
  endtask

  task t_err();
    set_in(FSM_OP, 4'hf, 2'b00, 2'b00);
    steady(1, 1'b1);
    set_in(FSM_OP, 4'h7, 2'b00, 2'b00);
    pattern(1, 200, 1000, 200, 200);
    set_in(FSM_OP, 4'h3, 2'b00, 2'b00);
    pattern(1, 200, 1000, 0, 0);
    set_in(FSM_OP, 4'h1, 2'b00, 2'b00);
    pattern(1, 200, 200, 0, 0);
    set_in(FSM_OP, 4'h0, 2'b00, 2'b00);
    steady(1, 1'b0);
  endtask

  task t_link();
    set_in(FSM_OP, 4'h0, 2'b01, 2'b00);
    steady(2, 1'b1);
    steady(3, 1'b0);
    set_in(FSM_OP, 4'h0, 2'b11, 2'b01);
    pattern(2, 50, 50, 0, 0);
    steady(3, 1'b1);
    set_in(FSM_OP, 4'h0, 2'b00, 2'b11);
    steady(2, 1'b0);
    steady(3, 1'b0);
  endtask

  // mid-run reset: dark while held, then back to the selected levels
  task t_reset();
    set_in(FSM_OP, 4'hf, 2'b11, 2'b00);
    rstn_i = 1'b0;
    @(posedge core_clk_i);
    #1;
    check({run_state_led_o, error_state_led_o, link_led_o},
          4'h0);
    rstn_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    check({run_state_led_o, error_state_led_o, link_led_o},
          4'hf);
  endtask

  // reset falls at 1 ns so the asynchronous clear sees a real edge
  initial begin
    rstn_i = 1'b1;
    #1;
    rstn_i = 1'b0;
    fsm_state_i = FSM_INIT;
    {err_critical_i, err_sm_watchdog_i, err_self_change_i, err_refused_i} = 4'h0;
    link_up_i = 2'b00;
    activity_i = 2'b00;
    repeat (10) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    t_run();
    t_err();
    t_link();
    t_reset();
    wrap_up();
  end
endmodule
